/* File: rtl/fwks_pkg.sv */
// Purpose: Constants for the keyed flash write and erase sequencer.
// Assumes: 50 MHz mclk, 32-bit Avalon-MM register bus.
// Notes: Function
package fwks_pkg;
	localparam int          FWKS_AW          = 14;
	localparam int          FWKS_DEPTH       = 16384;
	localparam int          FWKS_PAGE_BITS   = 9;
	localparam logic [9:0]  FWKS_PAGE_BYTES  = 10'h200;
	localparam logic [7:0]  FWKS_ERASED      = 8'hff;
	localparam logic [7:0]  FWKS_KEY_FIRST   = 8'ha5;
	localparam logic [7:0]  FWKS_KEY_SECOND  = 8'hf1;
	// Register byte addresses.
	localparam logic [3:0]  FWKS_OFF_CTRL    = 4'h0;
	localparam logic [3:0]  FWKS_OFF_KEY     = 4'h4;
	localparam logic [3:0]  FWKS_OFF_SUPPLY  = 4'h8;
	localparam logic [3:0]  FWKS_OFF_CAUSE   = 4'hc;
	// Field positions.
	localparam int          FWKS_B_WREN      = 0;
	localparam int          FWKS_B_EREN      = 1;
	localparam int          FWKS_B_MON_EN    = 0;
	localparam int          FWKS_B_MON_RST   = 1;
	localparam int          FWKS_B_FERR      = 0;
	localparam int          FWKS_B_ARMED     = 1;
	localparam int          FWKS_B_LOCKED    = 2;
	localparam int          FWKS_B_BUSY      = 3;
	// Timing.
	localparam int          FWKS_CLK_MHZ     = 50;
	localparam int          FWKS_WRITE_US    = 20;
	localparam int          FWKS_WRITE_CYC   = FWKS_WRITE_US * FWKS_CLK_MHZ;
	localparam logic [31:0] FWKS_RST_PULSE   = 32'h0000_0004;
	typedef enum logic [2:0] {fwks_idle, fwks_write, fwks_erase, fwks_hold} fwks_state_t;
endpackage

/* File: rtl/fwks_sequencer.sv */
// Purpose: Keyed flash write and erase sequencer with flash array.
// Assumes: Core issues one data-move write at a time as a one-cycle strobe, none while stalled.
// Notes: Registers on Avalon-MM; debug port writes flash directly.
`timescale 1ns/10ps
module fwks_sequencer
	import fwks_pkg::*;
#(
	parameter int ERASE_CYC = 1000000
) (
	// Clock and reset.
	input  wire logic                mclk,
	input  wire logic                reset,
	// Avalon-MM register slave.
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic      [31:0]         avs_readdata,
	output logic                     avs_waitrequest,
	// Core data-move and code-move ports.
	input  wire logic                dm_write,
	input  wire logic [FWKS_AW-1:0]  dm_addr,
	input  wire logic [7:0]          dm_wdata,
	output logic                     ram_write,
	output logic      [FWKS_AW-1:0]  ram_addr,
	output logic      [7:0]          ram_wdata,
	input  wire logic                cm_read,
	input  wire logic [FWKS_AW-1:0]  cm_addr,
	output logic      [7:0]          cm_rdata,
	output logic                     core_stall,
	// Debug programming port: write strobe, address, data and page erase.
	input  wire logic                dbg_write,
	input  wire logic [FWKS_AW-1:0]  dbg_addr,
	input  wire logic [7:0]          dbg_wdata,
	input  wire logic                dbg_erase,
	// Reset request to the system and power-on strobe.
	input  wire logic                por,
	output logic                     flash_error_reset
);

	logic [7:0]         mem [0:FWKS_DEPTH-1];
	fwks_state_t        state;
	logic               store_write_enable;
	logic               store_erase_enable;
	logic               mon_en;
	logic               mon_rst;
	logic               flash_error_reset_flag;
	logic               key_half;
	logic               armed;
	logic               locked;
	logic [31:0]        tcount;
	logic [31:0]        rcount;
	logic [FWKS_AW-1:0] op_addr;
	logic [7:0]         op_data;
	logic [8:0]         erase_idx;
	logic               wr_ok;
	logic               key_wr;
	logic               attempt;
	logic               safe;

	// ************************************************************
	// Bus decode
	// ************************************************************
	assign wr_ok   = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign key_wr  = wr_ok && avs_address == FWKS_OFF_KEY;
	assign attempt = dm_write && store_write_enable && state == fwks_idle;
	assign safe    = mon_en && mon_rst;

	// One wait state per access.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(avs_read || avs_write) || !avs_waitrequest;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			// Loaded in the wait cycle so the word stands at the accepting edge.
			case (avs_address)
				FWKS_OFF_CTRL:   avs_readdata <= {30'h0, store_erase_enable, store_write_enable};
				FWKS_OFF_SUPPLY: avs_readdata <= {30'h0, mon_rst, mon_en};
				FWKS_OFF_CAUSE:  avs_readdata <= {28'h0, core_stall, locked, armed,
					flash_error_reset_flag};
				default:         avs_readdata <= 32'h0;
			endcase
		end
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	// enables held by software
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			store_write_enable <= 1'b0;
			store_erase_enable <= 1'b0;
		end else if (wr_ok && avs_address == FWKS_OFF_CTRL) begin
			store_write_enable <= avs_writedata[FWKS_B_WREN];
			store_erase_enable <= avs_writedata[FWKS_B_EREN];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			mon_en  <= 1'b1;
			mon_rst <= 1'b1;
		end else if (por) begin
			mon_en  <= 1'b1;
			mon_rst <= 1'b1;
		end else if (wr_ok && avs_address == FWKS_OFF_SUPPLY) begin
			mon_en  <= avs_writedata[FWKS_B_MON_EN];
			mon_rst <= avs_writedata[FWKS_B_MON_RST];
		end
	end

	// cause flag survives its own reset
	always_ff @(posedge mclk) begin
		if (por) begin
			flash_error_reset_flag <= 1'b0;
		end else if (flash_error_reset) begin
			flash_error_reset_flag <= 1'b1;
		end else if (wr_ok && avs_address == FWKS_OFF_CAUSE) begin
			flash_error_reset_flag <= avs_writedata[FWKS_B_FERR];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rcount            <= 32'h0;
			flash_error_reset <= 1'b0;
		end else if (attempt && !safe) begin
			rcount            <= FWKS_RST_PULSE;
			flash_error_reset <= 1'b1;
		end else if (rcount != 32'h0) begin
			rcount            <= rcount - 32'h1;
			flash_error_reset <= rcount != 32'h1;
		end
	end

	// ************************************************************
	// Key checker
	// ************************************************************
	// lock and key
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			key_half <= 1'b0;
			armed    <= 1'b0;
			locked   <= 1'b0;
		end else if (key_wr) begin
			if (locked || armed) begin
				locked <= 1'b1;
				armed  <= 1'b0;
			end else if (!key_half && avs_writedata[7:0] == FWKS_KEY_FIRST) begin
				key_half <= 1'b1;
			end else if (key_half && avs_writedata[7:0] == FWKS_KEY_SECOND) begin
				key_half <= 1'b0;
				armed    <= 1'b1;
			end else begin
				key_half <= 1'b0;
				locked   <= 1'b1;
			end
		end else if (attempt) begin
			// Any attempt consumes the key; an unarmed safe attempt also locks.
			key_half <= 1'b0;
			armed    <= 1'b0;
			locked   <= locked || (safe && !armed);
		end
	end

	// ************************************************************
	// Operation timer and flash array
	// ************************************************************
	// timed operation with stall
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state      <= fwks_idle;
			tcount     <= 32'h0;
			op_addr    <= '0;
			op_data    <= 8'h0;
			core_stall <= 1'b0;
		end else begin
			case (state)
				fwks_idle: begin
					if (attempt && safe && armed && !locked) begin
						op_addr    <= dm_addr;
						op_data    <= dm_wdata;
						core_stall <= 1'b1;
						if (store_erase_enable) begin
							tcount <= ERASE_CYC;
							state  <= fwks_erase;
						end else begin
							tcount <= FWKS_WRITE_CYC;
							state  <= fwks_write;
						end
					end
				end
				fwks_write, fwks_erase: begin
					tcount <= tcount - 32'h1;
					if (tcount == 32'h1) begin
						state <= fwks_hold;
					end
				end
				fwks_hold: begin
					core_stall <= 1'b0;
					state      <= fwks_idle;
				end
				default: state <= fwks_idle;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			erase_idx <= 9'h0;
		end else if (state == fwks_erase) begin
			erase_idx <= erase_idx + 9'h1;
		end else begin
			erase_idx <= 9'h0;
		end
	end

	always_ff @(posedge mclk) begin
		if (dbg_erase) begin
			for (int i = 0; i < FWKS_PAGE_BYTES; i++) begin
				mem[{dbg_addr[FWKS_AW-1:FWKS_PAGE_BITS], i[8:0]}] <= FWKS_ERASED;
			end
		end else if (dbg_write) begin
			mem[dbg_addr] <= mem[dbg_addr] & dbg_wdata;
		end else if (state == fwks_write && tcount == 32'h1) begin
			mem[op_addr] <= mem[op_addr] & op_data;
		end else if (state == fwks_erase) begin
			mem[{op_addr[FWKS_AW-1:FWKS_PAGE_BITS], erase_idx}] <= FWKS_ERASED;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cm_rdata <= 8'h0;
		end else if (cm_read) begin
			cm_rdata <= mem[cm_addr];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ram_write <= 1'b0;
			ram_addr  <= '0;
			ram_wdata <= 8'h0;
		end else begin
			ram_write <= dm_write && !store_write_enable;
			ram_addr  <= dm_addr;
			ram_wdata <= dm_wdata;
		end
	end

endmodule // fwks_sequencer

/* File: testbench/fwks_asserts.sv */
// Purpose: Port checker for the keyed flash sequencer.
// Assumes: One clock domain, reset async active high.
// Notes: Bound to every fwks_sequencer instance.
`timescale 1ns/10ps
module fwks_asserts
	import fwks_pkg::*;
#(
	parameter int ERASE_CYC = 1000000
) (
	// Clock, reset and watched ports.
	input  wire logic                mclk,
	input  wire logic                reset,
	input  wire logic                dm_write,
	input  wire logic [FWKS_AW-1:0]  dm_addr,
	input  wire logic [7:0]          dm_wdata,
	input  wire logic                ram_write,
	input  wire logic [FWKS_AW-1:0]  ram_addr,
	input  wire logic [7:0]          ram_wdata,
	input  wire logic                core_stall,
	input  wire logic                flash_error_reset
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic [19:0] scnt;
	// Counts the cycles of the current stall.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			scnt <= 20'h0;
		else
			scnt <= core_stall ? scnt + 20'h1 : 20'h0;
	end
	property p_stall_len;
		$fell(core_stall) |-> scnt == FWKS_WRITE_CYC + 1 || scnt == ERASE_CYC + 1;
	endproperty
	a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
	property p_stall_min;
		$rose(core_stall) |-> core_stall [*8];
	endproperty
	a_stall_min: assert property (p_stall_min) else $error("stall too short");
	property p_stall_src;
		$rose(core_stall) |-> $past(dm_write);
	endproperty
	a_stall_src: assert property (p_stall_src) else $error("stall without write");
	property p_route;
		$rose(core_stall) |-> !ram_write;
	endproperty
	a_route: assert property (p_route) else $error("write went to ram and flash");
	property p_fer_len;
		$rose(flash_error_reset) |-> flash_error_reset [*4] ##1 !flash_error_reset;
	endproperty
	a_fer_len: assert property (p_fer_len) else $error("error pulse length");
	property p_fer_noop;
		flash_error_reset |-> !core_stall;
	endproperty
	a_fer_noop: assert property (p_fer_noop) else $error("operation ran on error");
	property p_fer_src;
		$rose(flash_error_reset) |-> $past(dm_write);
	endproperty
	a_fer_src: assert property (p_fer_src) else $error("error without write");
	property p_ram;
		ram_write |-> $past(dm_write) && ram_addr == $past(dm_addr) && ram_wdata == $past(dm_wdata);
	endproperty
	a_ram: assert property (p_ram) else $error("ram write mismatch");
	c_stall: cover property ($rose(core_stall));
	c_fer: cover property ($rose(flash_error_reset));
	c_ram: cover property (ram_write);
endmodule // fwks_asserts

bind fwks_sequencer fwks_asserts #(.ERASE_CYC(ERASE_CYC)) chk_u (.mclk(mclk), .reset(reset),
	.dm_write(dm_write), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .ram_write(ram_write),
	.ram_addr(ram_addr), .ram_wdata(ram_wdata), .core_stall(core_stall),
	.flash_error_reset(flash_error_reset));

/* File: testbench/fwks_core_model.sv */
// Purpose: Core model issuing data-move writes.
// Assumes: One request per go pulse.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/10ps
module fwks_core_model
	import fwks_pkg::*;
(
	// Clock and request.
	input  wire logic                mclk,
	input  wire logic                go,
	input  wire logic [FWKS_AW-1:0]  go_addr,
	input  wire logic [7:0]          go_data,
	// Data-move bus.
	input  wire logic                core_stall,
	output logic                     dm_write = 1'b0,
	output logic      [FWKS_AW-1:0]  dm_addr = 14'h0,
	output logic      [7:0]          dm_wdata = 8'h0
);
	always @(posedge mclk) begin
		if (go && core_stall !== 1'b1) begin
			dm_write <= 1'b1;
			dm_addr <= go_addr;
			dm_wdata <= go_data;
		end else begin
			dm_write <= 1'b0;
			dm_addr <= ~dm_addr;
			dm_wdata <= ~dm_wdata;
		end
	end
endmodule // fwks_core_model

/* File: testbench/fwks_sequencer_bench.sv */
// Purpose: Self-checking bench for the keyed flash sequencer.
// Assumes: Erase shortened to 600 cycles.
// Notes: Flash checked through the code-move port.
`timescale 1ns/10ps
module fwks_sequencer_bench
	import fwks_pkg::*;
;
	logic mclk = 1'b0, reset = 1'b1, por = 1'b0, go = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, ram_write, core_stall;
	logic dm_write, dbg_write = 1'b0, dbg_erase = 1'b0, flash_error_reset;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rdata;
	logic [FWKS_AW-1:0] dm_addr, ram_addr, cm_addr = 14'h0, dbg_addr = 14'h0, go_addr = 14'h0;
	logic [7:0] dm_wdata, ram_wdata, cm_rdata, dbg_wdata = 8'h0, go_data = 8'h0;
	int n_fail = 0, checked = 0, fer_n = 0;
	logic [21:0] ram_last = 22'h0;
	always @(posedge mclk) begin
		if (ram_write === 1'b1)
			ram_last <= {ram_addr, ram_wdata};
		if (flash_error_reset === 1'b1)
			fer_n <= fer_n + 1;
	end
	fwks_sequencer #(.ERASE_CYC(600)) dut_u (.mclk(mclk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .dm_write(dm_write), .dm_addr(dm_addr),
		.dm_wdata(dm_wdata), .ram_write(ram_write), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.cm_read(1'b1), .cm_addr(cm_addr), .cm_rdata(cm_rdata), .core_stall(core_stall),
		.dbg_write(dbg_write), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
		.dbg_erase(dbg_erase), .por(por), .flash_error_reset(flash_error_reset));
	fwks_core_model core_u (.mclk(mclk), .go(go), .go_addr(go_addr), .go_data(go_data),
		.core_stall(core_stall), .dm_write(dm_write), .dm_addr(dm_addr), .dm_wdata(dm_wdata));
	initial begin
		forever #10 mclk = ~mclk;
	end
	task summarize;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rdata & m);
	endtask
	task keys;
		bus(1'b1, FWKS_OFF_KEY, {24'h0, FWKS_KEY_FIRST});
		bus(1'b1, FWKS_OFF_KEY, {24'h0, FWKS_KEY_SECOND});
	endtask
	task cw(input logic [FWKS_AW-1:0] a, input logic [7:0] d);
		@(posedge mclk);
		go <= 1'b1;
		go_addr <= a;
		go_data <= d;
		@(posedge mclk);
		go <= 1'b0;
		repeat (3) @(posedge mclk);
		while (core_stall !== 1'b0)
			@(posedge mclk);
	endtask
	task fr(input logic [FWKS_AW-1:0] a, input logic [7:0] e, input string nm);
		@(posedge mclk);
		cm_addr <= a;
		@(posedge mclk);
		@(negedge mclk);
		chk(nm, {24'h0, e}, {24'h0, cm_rdata});
	endtask
	task rst;
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
	endtask
	initial begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		por <= 1'b1;
		dbg_erase <= 1'b1;
		@(posedge mclk);
		por <= 1'b0;
		dbg_addr <= 14'h200;
		@(posedge mclk);
		dbg_erase <= 1'b0;
		dbg_write <= 1'b1;
		@(posedge mclk);
		dbg_write <= 1'b0;
		rd(FWKS_OFF_CTRL, 32'h0, 32'h3, "ctrl");
		rd(FWKS_OFF_SUPPLY, 32'h3, 32'h3, "supply");
		fr(14'h5, 8'hff, "blank");
		keys();
		bus(1'b1, FWKS_OFF_CTRL, 32'h1);
		cw(14'h5, 8'h3c);
		fr(14'h5, 8'h3c, "byte");
		rd(FWKS_OFF_CTRL, 32'h1, 32'h1, "wren held");
		keys();
		cw(14'h5, 8'hf0);
		fr(14'h5, 8'h30, "and");
		fr(14'h200, 8'h00, "debug");
		keys();
		bus(1'b1, FWKS_OFF_CTRL, 32'h3);
		cw(14'h100, 8'h55);
		fr(14'h5, 8'hff, "erased");
		fr(14'h1ff, 8'hff, "page end");
		fr(14'h200, 8'h00, "next page");
		bus(1'b1, FWKS_OFF_CTRL, 32'h0);
		keys();
		cw(14'h10, 8'h77);
		chk("ram", {10'h0, 14'h10, 8'h77}, {10'h0, ram_last});
		bus(1'b1, FWKS_OFF_CTRL, 32'h1);
		cw(14'h6, 8'h11);
		fr(14'h6, 8'h11, "keys kept");
		fr(14'h10, 8'hff, "ram only");
		bus(1'b1, FWKS_OFF_SUPPLY, 32'h1);
		keys();
		cw(14'h7, 8'h00);
		fr(14'h7, 8'hff, "unsafe");
		chk("error pulse", 32'h4, fer_n);
		rd(FWKS_OFF_CAUSE, 32'h1, 32'h1, "error flag");
		bus(1'b1, FWKS_OFF_SUPPLY, 32'h3);
		cw(14'h7, 8'h00);
		rd(FWKS_OFF_CAUSE, 32'h4, 32'h4, "unarmed");
		for (int i = 0; i < 2; i++) begin
			rst();
			rd(FWKS_OFF_CAUSE, 32'h0, 32'h4, "unlocked");
			bus(1'b1, FWKS_OFF_KEY, i == 0 ? 32'h12 : 32'ha5);
			if (i == 1) begin
				bus(1'b1, FWKS_OFF_KEY, {24'h0, FWKS_KEY_SECOND});
				bus(1'b1, FWKS_OFF_KEY, {24'h0, FWKS_KEY_FIRST});
			end
			rd(FWKS_OFF_CAUSE, 32'h4, 32'h4, "locked");
			keys();
			bus(1'b1, FWKS_OFF_CTRL, 32'h1);
			cw(14'h8, 8'h00);
			fr(14'h8, 8'hff, "kept");
		end
		summarize();
	end
endmodule // fwks_sequencer_bench
